// [dsi_pkg.sv]
// package: constants, register map and carrier types of the diagnostic status indicator
`default_nettype none

package dsi_pkg;

    ////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int NUM_CH    = 8;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int CODE_W    = 8;
    localparam int NUM_EVT   = 6;

    ////////////////////////////////////////////////////////////////////////
    // clock and indicator flash timing
    localparam int CLK_HZ            = 40_000_000;
    localparam int FLASH_HALF_MS     = 250;
    localparam int FLASH_HALF_CYCLES = (CLK_HZ / 1000) * FLASH_HALF_MS;
    localparam int FLASH_CNT_W       = 24;

    ////////////////////////////////////////////////////////////////////////
    // diagnostic error codes
    localparam logic [CODE_W-1:0] CODE_NONE       = 8'h00;
    localparam logic [CODE_W-1:0] CODE_SHORT_GND  = 8'h01;
    localparam logic [CODE_W-1:0] CODE_WIRE_BREAK = 8'h06;
    localparam logic [CODE_W-1:0] CODE_OVERFLOW   = 8'h07;
    localparam logic [CODE_W-1:0] CODE_UNDERFLOW  = 8'h08;
    localparam logic [CODE_W-1:0] CODE_PARAM_ERR  = 8'h10;
    localparam logic [CODE_W-1:0] CODE_LOAD_MISS  = 8'h11;

    ////////////////////////////////////////////////////////////////////////
    // event bit positions in status and mask registers
    localparam int EVT_SHORT  = 0;
    localparam int EVT_WIRE   = 1;
    localparam int EVT_OVER   = 2;
    localparam int EVT_UNDER  = 3;
    localparam int EVT_PARAM  = 4;
    localparam int EVT_LOAD   = 5;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CH_ENABLE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_QUALITY   = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_REC0      = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_REC1_LO   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_REC1_HI   = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_ALARM     = 8'h1c;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [NUM_CH-1:0]  RST_CH_ENABLE = 8'hff;
    localparam logic [NUM_EVT-1:0] RST_IRQ_MASK  = 6'h00;

    ////////////////////////////////////////////////////////////////////////
    // field positions inside record 0 and the alarm register
    localparam int REC0_LOAD_BIT  = 8;
    localparam int REC0_HW_BIT    = 9;
    localparam int REC0_FAULT_BIT = 10;
    localparam int REC0_PARM_BIT  = 11;
    localparam int ALARM_CH_LSB   = 8;
    localparam int ALARM_VLD_BIT  = 31;

    ////////////////////////////////////////////////////////////////////////
    // carrier types
    typedef struct packed {
        logic              busVoltOk;
        logic              loadSupplyOk;
        logic              hwFault;
        logic [NUM_CH-1:0] chOpen;
        logic [NUM_CH-1:0] chShort;
    } dsi_pins_t;

    // synchroniser reset: supply taken as present so no false load event follows reset
    localparam dsi_pins_t RST_PINS = '{busVoltOk: 1'b0, loadSupplyOk: 1'b1, hwFault: 1'b0,
                                       chOpen: '0, chShort: '0};

    typedef struct packed {
        logic              paramValid;
        logic [NUM_CH-1:0] overflow;
        logic [NUM_CH-1:0] underflow;
        logic [NUM_CH-1:0] paramErr;
    } dsi_conv_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } dsi_bus_req_t;

    typedef enum logic [2:0] {
        MOD_UNPOWERED,
        MOD_STARTING,
        MOD_CONFIGURED,
        MOD_CH_FAULT,
        MOD_HW_DEFECT
    } dsi_mode_t;

endpackage

`default_nettype wire

// [dsi_diag_status.sv]
// module: indicator drive, diagnostic detection, alarms and register port of the analog output module
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module dsi_diag_status #(
    parameter int FLASH_HALF_CYCLES = dsi_pkg::FLASH_HALF_CYCLES
) (
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    // asynchronous pins
    input  wire dsi_pkg::dsi_pins_t            pins,
    // converter status, same clock
    input  wire dsi_pkg::dsi_conv_t            conv,
    // register port
    input  wire dsi_pkg::dsi_bus_req_t         busReq,
    output logic     [dsi_pkg::DATA_W-1:0]     busRdata,
    // indicators
    output logic                               runInd,
    output logic                               errInd,
    output logic                               supplyInd,
    output logic     [dsi_pkg::NUM_CH-1:0]     chIndGood,
    output logic     [dsi_pkg::NUM_CH-1:0]     chIndFault,
    // quality bits and interrupt
    output logic     [dsi_pkg::NUM_CH-1:0]     qualityBits,
    output logic                               irq
);
    import dsi_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    dsi_pins_t pinsMeta_q;
    dsi_pins_t pinsSync_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pinsMeta_q <= RST_PINS;
            pinsSync_q <= RST_PINS;
        end else begin
            pinsMeta_q <= pins;
            pinsSync_q <= pinsMeta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers
    logic [NUM_CH-1:0]  chEnable_q;
    logic [NUM_EVT-1:0] irqMask_q;
    logic [NUM_EVT-1:0] irqStat_q;
    logic [NUM_EVT-1:0] irqStat_d;
    logic               wrEnable;
    logic               wrMask;
    logic               wrStat;

    assign wrEnable = busReq.wr && (busReq.addr == OFS_CH_ENABLE);
    assign wrMask   = busReq.wr && (busReq.addr == OFS_IRQ_MASK);
    assign wrStat   = busReq.wr && (busReq.addr == OFS_IRQ_STAT);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chEnable_q <= RST_CH_ENABLE;
        end else if (wrEnable) begin
            chEnable_q <= busReq.wdata[NUM_CH-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqMask_q <= RST_IRQ_MASK;
        end else if (wrMask) begin
            irqMask_q <= busReq.wdata[NUM_EVT-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel conditions and codes
    logic [NUM_CH-1:0] condShort;
    logic [NUM_CH-1:0] condWire;
    logic [NUM_CH-1:0] condOver;
    logic [NUM_CH-1:0] condUnder;
    logic [NUM_CH-1:0] condParam;
    logic [NUM_CH-1:0] chFault;
    logic [CODE_W-1:0] chCode [NUM_CH];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            // conditions are plain levels: pending while the cause persists
            assign condShort[gi] = chEnable_q[gi] && pinsSync_q.chShort[gi];
            assign condWire[gi]  = chEnable_q[gi] && pinsSync_q.chOpen[gi];
            assign condOver[gi]  = chEnable_q[gi] && conv.overflow[gi];
            assign condUnder[gi] = chEnable_q[gi] && conv.underflow[gi];
            assign condParam[gi] = chEnable_q[gi] && conv.paramErr[gi];
            assign chFault[gi]   = condShort[gi] || condWire[gi] || condOver[gi]
                                 || condUnder[gi] || condParam[gi];

            // most severe cause first when several are pending
            always_comb begin
                if (condParam[gi]) begin
                    chCode[gi] = CODE_PARAM_ERR;
                end else if (condShort[gi]) begin
                    chCode[gi] = CODE_SHORT_GND;
                end else if (condWire[gi]) begin
                    chCode[gi] = CODE_WIRE_BREAK;
                end else if (condOver[gi]) begin
                    chCode[gi] = CODE_OVERFLOW;
                end else if (condUnder[gi]) begin
                    chCode[gi] = CODE_UNDERFLOW;
                end else begin
                    chCode[gi] = CODE_NONE;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // module-level conditions
    logic               loadMissing;
    logic               loadMissing_q;
    logic               anyFault;
    logic [NUM_CH-1:0]  condShort_q;
    logic [NUM_CH-1:0]  condWire_q;
    logic [NUM_CH-1:0]  condOver_q;
    logic [NUM_CH-1:0]  condUnder_q;
    logic [NUM_CH-1:0]  condParam_q;
    logic [NUM_EVT-1:0] evtRise;

    assign loadMissing = !pinsSync_q.loadSupplyOk;
    assign anyFault    = (|chFault) || loadMissing;

    // per-channel history: a new channel raises its type again while another still holds it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            condShort_q   <= '0;
            condWire_q    <= '0;
            condOver_q    <= '0;
            condUnder_q   <= '0;
            condParam_q   <= '0;
            loadMissing_q <= 1'b0;
        end else begin
            condShort_q   <= condShort;
            condWire_q    <= condWire;
            condOver_q    <= condOver;
            condUnder_q   <= condUnder;
            condParam_q   <= condParam;
            loadMissing_q <= loadMissing;
        end
    end

    assign evtRise[EVT_SHORT] = |(condShort & ~condShort_q);
    assign evtRise[EVT_WIRE]  = |(condWire & ~condWire_q);
    assign evtRise[EVT_OVER]  = |(condOver & ~condOver_q);
    assign evtRise[EVT_UNDER] = |(condUnder & ~condUnder_q);
    assign evtRise[EVT_PARAM] = |(condParam & ~condParam_q);
    assign evtRise[EVT_LOAD]  = loadMissing && !loadMissing_q;

    ////////////////////////////////////////////////////////////////////////
    // interrupt status: set wins over write-one-to-clear
    always_comb begin
        irqStat_d = irqStat_q;
        if (wrStat) begin
            irqStat_d = irqStat_d & ~busReq.wdata[NUM_EVT-1:0];
        end
        irqStat_d = irqStat_d | evtRise;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqStat_q <= '0;
        end else begin
            irqStat_q <= irqStat_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStat_d & irqMask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alarm info: code and channel of the latest load loss, else of the lowest-numbered channel entering fault in that cycle
    logic [CODE_W-1:0] alarmCode_q;
    logic [2:0]        alarmCh_q;
    logic              alarmVld_q;
    logic [NUM_CH-1:0] chFault_q;
    logic [NUM_CH-1:0] chRise;
    logic [2:0]        riseIdx;

    assign chRise = chFault & ~chFault_q;

    always_comb begin
        riseIdx = 3'h0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (chRise[i]) begin
                riseIdx = 3'(i);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chFault_q <= '0;
        end else begin
            chFault_q <= chFault;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            alarmCode_q <= CODE_NONE;
            alarmCh_q   <= 3'h0;
            alarmVld_q  <= 1'b0;
        end else if (evtRise[EVT_LOAD]) begin
            alarmCode_q <= CODE_LOAD_MISS;
            alarmCh_q   <= 3'h0;
            alarmVld_q  <= 1'b1;
        end else if (|chRise) begin
            alarmCode_q <= chCode[riseIdx];
            alarmCh_q   <= riseIdx;
            alarmVld_q  <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flash timebase
    logic [FLASH_CNT_W-1:0] flashCnt_q;
    logic                   flashPhase_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flashCnt_q   <= '0;
            flashPhase_q <= 1'b0;
        end else if (flashCnt_q == FLASH_CNT_W'(FLASH_HALF_CYCLES - 1)) begin
            flashCnt_q   <= '0;
            flashPhase_q <= !flashPhase_q;
        end else begin
            flashCnt_q   <= flashCnt_q + FLASH_CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // module mode and run/error indicators
    dsi_mode_t mode;

    always_comb begin
        if (!pinsSync_q.busVoltOk) begin
            mode = MOD_UNPOWERED;
        end else if (pinsSync_q.hwFault) begin
            mode = MOD_HW_DEFECT;
        end else if (!conv.paramValid) begin
            mode = MOD_STARTING;
        end else if (anyFault) begin
            mode = MOD_CH_FAULT;
        end else begin
            mode = MOD_CONFIGURED;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            runInd <= 1'b0;
            errInd <= 1'b0;
        end else begin
            unique case (mode)
                MOD_UNPOWERED: begin
                    runInd <= 1'b0;
                    errInd <= 1'b0;
                end
                MOD_STARTING: begin
                    runInd <= flashPhase_q;
                    errInd <= 1'b0;
                end
                MOD_CONFIGURED: begin
                    runInd <= 1'b1;
                    errInd <= 1'b0;
                end
                MOD_CH_FAULT: begin
                    runInd <= 1'b1;
                    errInd <= flashPhase_q;
                end
                MOD_HW_DEFECT: begin
                    runInd <= flashPhase_q;
                    errInd <= flashPhase_q;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // supply, channel and quality outputs
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            supplyInd   <= 1'b0;
            chIndGood   <= '0;
            chIndFault  <= '0;
            qualityBits <= '0;
        end else begin
            supplyInd   <= pinsSync_q.loadSupplyOk;
            chIndGood   <= chEnable_q & ~chFault;
            chIndFault  <= chFault;
            qualityBits <= chEnable_q & ~chFault
                         & {NUM_CH{pinsSync_q.loadSupplyOk && conv.paramValid}};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // diagnostic records and register read port
    logic [DATA_W-1:0] rec0;
    logic [DATA_W-1:0] rec1Lo;
    logic [DATA_W-1:0] rec1Hi;
    logic [DATA_W-1:0] alarmWord;

    always_comb begin
        rec0                 = '0;
        rec0[NUM_CH-1:0]     = chFault;
        rec0[REC0_LOAD_BIT]  = loadMissing;
        rec0[REC0_HW_BIT]    = pinsSync_q.hwFault;
        rec0[REC0_FAULT_BIT] = anyFault;
        rec0[REC0_PARM_BIT]  = conv.paramValid;
    end

    assign rec1Lo = {chCode[3], chCode[2], chCode[1], chCode[0]};
    assign rec1Hi = {chCode[7], chCode[6], chCode[5], chCode[4]};

    always_comb begin
        alarmWord                                 = '0;
        alarmWord[CODE_W-1:0]                     = alarmCode_q;
        alarmWord[ALARM_CH_LSB+2:ALARM_CH_LSB]    = alarmCh_q;
        alarmWord[ALARM_VLD_BIT]                  = alarmVld_q;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busRdata <= '0;
        end else if (busReq.rd) begin
            unique case (busReq.addr)
                OFS_CH_ENABLE: busRdata <= DATA_W'(chEnable_q);
                OFS_IRQ_STAT:  busRdata <= DATA_W'(irqStat_q);
                OFS_IRQ_MASK:  busRdata <= DATA_W'(irqMask_q);
                OFS_QUALITY:   busRdata <= DATA_W'(qualityBits);
                OFS_REC0:      busRdata <= rec0;
                OFS_REC1_LO:   busRdata <= rec1Lo;
                OFS_REC1_HI:   busRdata <= rec1Hi;
                OFS_ALARM:     busRdata <= alarmWord;
                default:       busRdata <= '0;
            endcase
        end else begin
            busRdata <= '0;
        end
    end

endmodule // dsi_diag_status

`default_nettype wire

// [dsi_diag_status_properties.sv]
// checker: port-level properties of the diagnostic status indicator
`timescale 1ns/10ps
`default_nettype none
module dsi_diag_status_checker
    import dsi_pkg::*;
#(
    parameter int FLASH_HALF_CYCLES = 4
) (
    // clock and reset
    input wire logic                      clk_sys,
    input wire logic                      rst,
    // block inputs
    input wire dsi_pkg::dsi_pins_t        pins,
    input wire dsi_pkg::dsi_conv_t        conv,
    input wire dsi_pkg::dsi_bus_req_t     busReq,
    // block outputs
    input wire logic [dsi_pkg::DATA_W-1:0] busRdata,
    input wire logic                      runInd,
    input wire logic                      errInd,
    input wire logic                      supplyInd,
    input wire logic [dsi_pkg::NUM_CH-1:0] chIndGood,
    input wire logic [dsi_pkg::NUM_CH-1:0] chIndFault,
    input wire logic [dsi_pkg::NUM_CH-1:0] qualityBits,
    input wire logic                      irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // pin levels pass a two-stage synchroniser, so five cycles of margin
    a_bus_off_dark: assert property ((!pins.busVoltOk)[*5] |-> !runInd && !errInd)
        else $error("indicators lit without bus voltage");
    a_start_err_off: assert property ((pins.busVoltOk && !pins.hwFault && !conv.paramValid)[*5] |-> !errInd)
        else $error("error indicator lit while waiting for parameters");
    a_fault_run_on: assert property ((|chIndFault && pins.busVoltOk && !pins.hwFault && conv.paramValid)[*5]
        |-> runInd)
        else $error("run indicator off during channel fault");
    a_hw_in_phase: assert property ((pins.busVoltOk && pins.hwFault)[*5] |-> runInd == errInd)
        else $error("run and error not in phase on hardware defect");
    a_load_dark: assert property ((!pins.loadSupplyOk)[*5] |-> !supplyInd && qualityBits == '0)
        else $error("supply indicator or quality set without load supply");
    a_load_lit: assert property ((pins.loadSupplyOk)[*5] |-> supplyInd)
        else $error("supply indicator off with load supply present");
    a_good_not_fault: assert property ((chIndGood & chIndFault) == '0)
        else $error("channel shows good and fault together");
    a_quality_fault: assert property ((qualityBits & chIndFault) == '0)
        else $error("quality bit set on faulted channel");
    a_quality_param: assert property ((!conv.paramValid)[*2] |-> qualityBits == '0)
        else $error("quality bit set without valid parameters");
    a_rdata_idle: assert property (!$past(busReq.rd) |-> busRdata == '0)
        else $error("read data present without a read");
endmodule // dsi_diag_status_checker

bind dsi_diag_status dsi_diag_status_checker #(.FLASH_HALF_CYCLES(FLASH_HALF_CYCLES)) dsi_diag_status_checker_inst (
    .clk_sys(clk_sys), .rst(rst), .pins(pins), .conv(conv), .busReq(busReq), .busRdata(busRdata),
    .runInd(runInd), .errInd(errInd), .supplyInd(supplyInd), .chIndGood(chIndGood),
    .chIndFault(chIndFault), .qualityBits(qualityBits), .irq(irq));
`default_nettype wire

// [dsi_host_model.sv]
// partner: controller side of the register port, issuing single-cycle strobes
`timescale 1ns/10ps
`default_nettype none
module dsi_host_model
    import dsi_pkg::*;
(
    // clock
    input wire logic                       clk_sys,
    // register port
    output var dsi_pkg::dsi_bus_req_t      busReq,
    input wire logic [dsi_pkg::DATA_W-1:0] busRdata
);
    initial busReq = '0;

    // after a strobe the address and data lines are scrambled, not held
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        busReq <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask

    // records and status are fetched by a read request
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        busReq <= '{addr: ~a, wdata: 32'hffff_ffff, wr: 1'b0, rd: 1'b0};
        #1;
        d = busRdata;
    endtask
endmodule // dsi_host_model
`default_nettype wire

// [dsi_diag_status_tb_top.sv]
// testbench: directed register and indicator scenarios for the diagnostic status indicator
`timescale 1ns/10ps
`default_nettype none
module dsi_diag_status_tb_top;
    import dsi_pkg::*;
    logic              clk_sys;
    logic              rst;
    dsi_pins_t         pins;
    dsi_conv_t         conv;
    dsi_bus_req_t      busReq;
    logic [DATA_W-1:0] busRdata;
    logic              runInd, errInd, supplyInd, irq;
    logic [NUM_CH-1:0] chIndGood, chIndFault, qualityBits, bit1;
    logic [31:0]       rv;
    int                nFail, checkCount, hiRun, hiErr, same;
    logic [7:0]        codes [NUM_EVT] = '{CODE_SHORT_GND, CODE_WIRE_BREAK, CODE_OVERFLOW,
                                           CODE_UNDERFLOW, CODE_PARAM_ERR, CODE_LOAD_MISS};

    dsi_diag_status #(.FLASH_HALF_CYCLES(4)) dsi_diag_status_inst (
        .clk_sys(clk_sys), .rst(rst), .pins(pins), .conv(conv), .busReq(busReq), .busRdata(busRdata),
        .runInd(runInd), .errInd(errInd), .supplyInd(supplyInd), .chIndGood(chIndGood),
        .chIndFault(chIndFault), .qualityBits(qualityBits), .irq(irq));
    dsi_host_model dsi_host_model_inst (.clk_sys(clk_sys), .busReq(busReq), .busRdata(busRdata));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic reportAndStop;
        if (nFail == 0 && checkCount > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nFail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // counts lit cycles of run and error over a span
    task automatic watch(input int n);
        hiRun = 0;
        hiErr = 0;
        same = 0;
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            hiRun += (runInd === 1'b1);
            hiErr += (errInd === 1'b1);
            same += (runInd === errInd);
        end
    endtask

    task automatic rd(input logic [7:0] a);
        dsi_host_model_inst.rd_reg(a, rv);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        dsi_host_model_inst.wr_reg(a, d);
    endtask

    // applies or removes the cause of one event kind on one channel; kind 5 drops the load supply and ignores the channel
    task automatic cause(input int e, input int ch, input logic v);
        @(posedge clk_sys);
        case (e)
            0: pins.chShort[ch] <= v;
            1: pins.chOpen[ch] <= v;
            2: conv.overflow[ch] <= v;
            3: conv.underflow[ch] <= v;
            4: conv.paramErr[ch] <= v;
            default: pins.loadSupplyOk <= !v;
        endcase
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        pins = '0;
        pins.busVoltOk = 1'b1;
        pins.loadSupplyOk = 1'b1;
        conv = '0;
        nFail = 0;
        checkCount = 0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        waitc(4);
        rd(OFS_CH_ENABLE);
        check(rv, 32'h0000_00ff);
        rd(OFS_IRQ_MASK);
        check(rv, 32'h0);
        rd(OFS_IRQ_STAT);
        check(rv, 32'h0);
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40);
        check(rv, 32'h0);
        watch(24);
        check(hiErr, 0);
        check(hiRun > 0 && hiRun < 24, 1);
        @(posedge clk_sys);
        conv.paramValid <= 1'b1;
        waitc(4);
        watch(16);
        check(hiRun + hiErr, 16);
        check(chIndGood, 8'hff);
        check(qualityBits, 8'hff);
        check(supplyInd, 1);
        rd(OFS_REC0);
        check(rv[11:0], 12'h800);
        for (int e = 0; e < NUM_EVT; e++) begin
            bit1 = 8'h01 << e;
            wr(OFS_IRQ_MASK, 32'h0);
            wr(OFS_IRQ_STAT, 32'h3f);
            cause(e, e, 1'b1);
            waitc(6);
            check(irq, 0);
            rd(OFS_IRQ_STAT);
            check(rv, 32'h1 << e);
            wr(OFS_IRQ_MASK, 32'h1 << e);
            waitc(2);
            check(irq, 1);
            rd(OFS_ALARM);
            check({rv[31], rv[7:0]}, {1'b1, codes[e]});
            watch(16);
            check(hiRun, 16);
            check(hiErr > 0 && hiErr < 16, 1);
            if (e < 5) begin
                check(rv[10:8], e);
                check(chIndFault, bit1);
                check(qualityBits, 8'(~bit1));
                rd(e < 4 ? OFS_REC1_LO : OFS_REC1_HI);
                check(rv[(e % 4) * 8 +: 8], codes[e]);
                rd(OFS_REC0);
                check({rv[10], rv[7:0]}, {1'b1, bit1});
            end else begin
                check(supplyInd, 0);
                check(qualityBits, 8'h00);
                rd(OFS_REC0);
                check(rv[8], 1);
            end
            cause(e, e, 1'b0);
            waitc(6);
            check({chIndFault, qualityBits}, 16'h00ff);
            rd(OFS_IRQ_STAT);
            check(rv, 32'h1 << e);
            wr(OFS_IRQ_STAT, 32'h1 << e);
            waitc(2);
            check(irq, 0);
        end
        wr(OFS_CH_ENABLE, 32'hfd);
        wr(OFS_IRQ_STAT, 32'h3f);
        cause(1, 1, 1'b1);
        waitc(6);
        rd(OFS_IRQ_STAT);
        check(rv, 32'h0);
        check({chIndGood, chIndFault}, 16'hfd00);
        cause(1, 1, 1'b0);
        wr(OFS_CH_ENABLE, 32'hff);
        // a second channel of a type already pending raises the type again
        cause(0, 2, 1'b1);
        waitc(6);
        wr(OFS_IRQ_STAT, 32'h3f);
        cause(0, 5, 1'b1);
        waitc(6);
        rd(OFS_IRQ_STAT);
        check(rv, 32'h1);
        rd(OFS_ALARM);
        check(rv[10:8], 5);
        cause(0, 2, 1'b0);
        cause(0, 5, 1'b0);
        @(posedge clk_sys);
        pins.hwFault <= 1'b1;
        waitc(6);
        watch(16);
        check(same, 16);
        check(hiRun > 0 && hiRun < 16, 1);
        rd(OFS_REC0);
        check(rv[9], 1);
        @(posedge clk_sys);
        pins.hwFault <= 1'b0;
        pins.busVoltOk <= 1'b0;
        waitc(6);
        watch(16);
        check(hiRun + hiErr, 0);
        reportAndStop;
    end

    initial begin
        #(25 * 20000);
        nFail++;
        reportAndStop;
    end
endmodule // dsi_diag_status_tb_top
`default_nettype wire
